// ==== src/pif_pkg.sv ====
// package: register map, field positions and reset values of the flag block
`default_nettype none
package pif_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_MCTL = 8'h00;
	localparam logic [7:0] OFS_PEN1 = 8'h04;
	localparam logic [7:0] OFS_PEN2 = 8'h08;
	localparam logic [7:0] OFS_PREQ1 = 8'h0c;
	localparam logic [7:0] OFS_PREQ2 = 8'h10;
	localparam logic [7:0] OFS_EVT_STAT = 8'h14;
	localparam logic [7:0] OFS_EVT_EN = 8'h18;
	localparam logic [7:0] OFS_EVT_CLR = 8'h1c;
	// master control fields
	localparam int GLOBAL_EN_BIT = 7;
	localparam int PERIPH_EN_BIT = 6;
	localparam int T0_EN_BIT = 5;
	localparam int EXT_EN_BIT = 4;
	localparam int PCHG_EN_BIT = 3;
	localparam int T0_PEND_BIT = 2;
	localparam int EXT_PEND_BIT = 1;
	localparam int PCHG_PEND_BIT = 0;
	// writable bits of the master control register
	localparam logic [7:0] MCTL_WR_MASK = 8'hfe;
	// second enable and second flag registers: bits 7, 3, 0 exist
	localparam logic [7:0] REG2_MASK = 8'h89;
	// first flag register: serial receive and transmit are read-only
	localparam int SER_RX_BIT = 5;
	localparam int SER_TX_BIT = 4;
	localparam logic [7:0] PREQ1_WR_MASK = 8'hcf;
	// reset value of every control and flag register
	localparam logic [7:0] REG_RST = 8'h00;
	// event status layout
	localparam int EVT_W = 2;
	localparam int EVT_PSET_BIT = 0;
	localparam int EVT_CORE_BIT = 1;
	localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
	// bus answer
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== src/pif_flag_if.sv ====
// interface: control side to flag bank
`timescale 1ns/10ps
`default_nettype none
interface pif_flag_if;
	logic [7:0] set1; // set pulses, first flag register
	logic [7:0] set2; // set pulses, second flag register
	logic [1:0] ser_lvl; // serial receive/transmit request levels
	logic wr1; // software write to first flag register
	logic wr2; // software write to second flag register
	logic [7:0] wdata; // written byte
	logic [7:0] req1; // registered flags
	logic [7:0] req2;
	logic [7:0] nxt_req1; // flags as they will be after this edge
	logic [7:0] nxt_req2;
	modport ctrl (output set1, set2, ser_lvl, wr1, wr2, wdata,
		input req1, req2, nxt_req1, nxt_req2);
	modport bank (input set1, set2, ser_lvl, wr1, wr2, wdata,
		output req1, req2, nxt_req1, nxt_req2);
endinterface
`default_nettype wire

// ==== src/pif_flags.sv ====
// module: the two peripheral request flag registers
`timescale 1ns/10ps
`default_nettype none
module pif_flags
	import pif_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control side
	pif_flag_if.bank fl
);
	// all state of the bank
	typedef struct packed {
		logic [7:0] req1;
		logic [7:0] req2;
	} pif_flag_st_t;
	pif_flag_st_t s_ff; // registered state
	pif_flag_st_t nxt_s; // next state

	// next flag values: write first, then sets win over the write
	always_comb
	begin
		nxt_s = s_ff;
		if (fl.wr1)
		begin
			nxt_s.req1 = (s_ff.req1 & ~PREQ1_WR_MASK) |
				(fl.wdata & PREQ1_WR_MASK);
		end
		if (fl.wr2)
		begin
			nxt_s.req2 = fl.wdata & REG2_MASK;
		end
		nxt_s.req1 = nxt_s.req1 | fl.set1;
		nxt_s.req2 = (nxt_s.req2 | fl.set2) & REG2_MASK;
		// serial flags follow their source only, software cannot write
		nxt_s.req1[SER_RX_BIT] = fl.ser_lvl[1];
		nxt_s.req1[SER_TX_BIT] = fl.ser_lvl[0];
	end

	// flag registers, cleared by any reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_ff <= '{req1: REG_RST, req2: REG_RST};
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign fl.req1 = s_ff.req1;
	assign fl.req2 = s_ff.req2;
	assign fl.nxt_req1 = nxt_s.req1;
	assign fl.nxt_req2 = nxt_s.req2;

	// a set pulse always leaves its flag set
	a_set_wins_one: assert property (@(posedge hclk) disable iff (!hresetn)
		(fl.set1 & PREQ1_WR_MASK) != 8'h00 |=>
		(s_ff.req1 & $past(fl.set1) & PREQ1_WR_MASK) ==
		($past(fl.set1) & PREQ1_WR_MASK))
		else $error("first flag lost a set event");
	a_set_wins_two: assert property (@(posedge hclk) disable iff (!hresetn)
		(fl.set2 & REG2_MASK) != 8'h00 |=>
		(s_ff.req2 & $past(fl.set2) & REG2_MASK) ==
		($past(fl.set2) & REG2_MASK))
		else $error("second flag lost a set event");
	// unimplemented bits of the second flag register stay zero
	a_reg2_unused: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_ff.req2 & ~REG2_MASK) == 8'h00)
		else $error("unimplemented flag bit set");
	// a flag without set or write keeps its value
	a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		!fl.wr1 && fl.set1 == 8'h00 |=>
		(s_ff.req1 & PREQ1_WR_MASK) ==
		($past(s_ff.req1) & PREQ1_WR_MASK))
		else $error("flag changed without cause");
endmodule
`default_nettype wire

// ==== src/pif_top.sv ====
// module: peripheral interrupt enable and flag block with an ahb-lite slave
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pif_top
	import pif_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// first flag register sources, one-cycle pulses
	input wire logic timer1_gate_evt,
	input wire logic adc_done_evt,
	input wire logic sync_port_evt,
	input wire logic capcmp_one_evt,
	input wire logic timer2_match_evt,
	input wire logic timer1_overflow_evt,
	// serial request levels held by the serial unit
	input wire logic serial_receive_lvl,
	input wire logic serial_transmit_lvl,
	// second flag register sources, one-cycle pulses
	input wire logic osc_fail_evt,
	input wire logic bus_collision_evt,
	input wire logic capcmp_two_evt,
	// master control sources
	input wire logic timer0_overflow_evt,
	input wire logic ext_pin_evt,
	input wire logic pin_change_lvl,
	// requests
	output logic core_irq,
	output logic evt_irq
);
	// all state of the control side
	typedef struct packed {
		logic [7:0] mctl; // master control
		logic [7:0] pen1; // first enable
		logic [7:0] pen2; // second enable
		logic [EVT_W-1:0] evt_stat; // sticky event status
		logic [EVT_W-1:0] evt_en; // event enable
		logic dp_wr; // a write data phase is pending
		logic [ADDR_W-1:0] dp_addr; // its address
		logic [31:0] rdata; // read data for the data phase
		logic core_irq; // registered core request
		logic evt_irq; // registered event interrupt
	} pif_top_st_t;
	pif_top_st_t s_ff; // registered state
	pif_top_st_t nxt_s; // next state
	pif_flag_if fl (); // link to the flag bank

	// full address match; offsets are byte addresses, upper bits zero
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	// gated request from enables, flags and master control
	function automatic logic req_of(input logic [7:0] mc,
		input logic [7:0] e1, input logic [7:0] e2,
		input logic [7:0] f1, input logic [7:0] f2);
		logic per;
		logic own;
		per = mc[PERIPH_EN_BIT] & (|(e1 & f1) | |(e2 & f2 & REG2_MASK));
		own = (mc[T0_EN_BIT] & mc[T0_PEND_BIT]) |
			(mc[EXT_EN_BIT] & mc[EXT_PEND_BIT]) |
			(mc[PCHG_EN_BIT] & mc[PCHG_PEND_BIT]);
		req_of = mc[GLOBAL_EN_BIT] & (per | own);
	endfunction

	logic addr_ok; // an accepted address phase this cycle
	logic [7:0] wbyte; // written byte of the data phase
	logic nxt_core; // request after this edge
	assign addr_ok = hsel & htrans[1] & hready;
	assign wbyte = hwdata[7:0];

	// flag bank inputs
	always_comb
	begin
		fl.set1 = {timer1_gate_evt, adc_done_evt, 2'b00, sync_port_evt,
			capcmp_one_evt, timer2_match_evt, timer1_overflow_evt};
		fl.set2 = {osc_fail_evt, 3'b000, bus_collision_evt, 2'b00,
			capcmp_two_evt};
		fl.ser_lvl = {serial_receive_lvl, serial_transmit_lvl};
		fl.wr1 = s_ff.dp_wr & hit(s_ff.dp_addr, OFS_PREQ1);
		fl.wr2 = s_ff.dp_wr & hit(s_ff.dp_addr, OFS_PREQ2);
		fl.wdata = wbyte;
	end

	pif_flags u_flags (
		.hclk(hclk),
		.hresetn(hresetn),
		.fl(fl)
	);

	// next state of registers, bus and requests
	always_comb
	begin
		nxt_s = s_ff;
		// data phase writes
		if (s_ff.dp_wr)
		begin
			if (hit(s_ff.dp_addr, OFS_MCTL))
			begin
				nxt_s.mctl = (s_ff.mctl & ~MCTL_WR_MASK) |
					(wbyte & MCTL_WR_MASK);
			end
			if (hit(s_ff.dp_addr, OFS_PEN1))
			begin
				nxt_s.pen1 = wbyte;
			end
			if (hit(s_ff.dp_addr, OFS_PEN2))
			begin
				nxt_s.pen2 = wbyte & REG2_MASK;
			end
			if (hit(s_ff.dp_addr, OFS_EVT_EN))
			begin
				nxt_s.evt_en = wbyte[EVT_W-1:0];
			end
			if (hit(s_ff.dp_addr, OFS_EVT_CLR))
			begin
				nxt_s.evt_stat = s_ff.evt_stat & ~wbyte[EVT_W-1:0];
			end
		end
		// timer0 and external pin flags set by their sources, set wins; pin change flag follows its level
		if (timer0_overflow_evt)
		begin
			nxt_s.mctl[T0_PEND_BIT] = 1'b1;
		end
		if (ext_pin_evt)
		begin
			nxt_s.mctl[EXT_PEND_BIT] = 1'b1;
		end
		nxt_s.mctl[PCHG_PEND_BIT] = pin_change_lvl;
		// gated core request from the next register values
		nxt_core = req_of(nxt_s.mctl, nxt_s.pen1, nxt_s.pen2,
			fl.nxt_req1, fl.nxt_req2);
		nxt_s.core_irq = nxt_core;
		// sticky events, set wins over the clear write
		if ((fl.set1 | fl.set2) != 8'h00)
		begin
			nxt_s.evt_stat[EVT_PSET_BIT] = 1'b1;
		end
		if (nxt_core && !s_ff.core_irq)
		begin
			nxt_s.evt_stat[EVT_CORE_BIT] = 1'b1;
		end
		nxt_s.evt_irq = |(nxt_s.evt_stat & nxt_s.evt_en);
		// address phase: latch write, or capture read data now
		nxt_s.dp_wr = addr_ok & hwrite;
		nxt_s.dp_addr = haddr;
		nxt_s.rdata = RDATA_RST;
		if (addr_ok && !hwrite)
		begin
			unique case (1'b1)
				hit(haddr, OFS_MCTL): nxt_s.rdata[7:0] = nxt_s.mctl;
				hit(haddr, OFS_PEN1): nxt_s.rdata[7:0] = nxt_s.pen1;
				hit(haddr, OFS_PEN2): nxt_s.rdata[7:0] = nxt_s.pen2;
				hit(haddr, OFS_PREQ1): nxt_s.rdata[7:0] = fl.nxt_req1;
				hit(haddr, OFS_PREQ2): nxt_s.rdata[7:0] = fl.nxt_req2;
				hit(haddr, OFS_EVT_STAT):
					nxt_s.rdata[EVT_W-1:0] = nxt_s.evt_stat;
				hit(haddr, OFS_EVT_EN):
					nxt_s.rdata[EVT_W-1:0] = nxt_s.evt_en;
				// unmapped and write-only addresses read zero
				default: nxt_s.rdata = RDATA_RST;
			endcase
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_ff.mctl <= REG_RST;
			s_ff.pen1 <= REG_RST;
			s_ff.pen2 <= REG_RST;
			s_ff.evt_stat <= EVT_RST;
			s_ff.evt_en <= EVT_RST;
			s_ff.dp_wr <= 1'b0;
			s_ff.dp_addr <= '0;
			s_ff.rdata <= RDATA_RST;
			s_ff.core_irq <= 1'b0;
			s_ff.evt_irq <= 1'b0;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	// zero-wait slave; answer is always okay
	logic ready_ff; // high from reset on, stays
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ready_ff <= 1'b1;
		end
		else
		begin
			ready_ff <= 1'b1;
		end
	end

	// outputs straight from flip-flops
	assign hreadyout = ready_ff;
	assign hresp = 1'b0 & ready_ff;
	assign hrdata = s_ff.rdata;
	assign core_irq = s_ff.core_irq;
	assign evt_irq = s_ff.evt_irq;

	// request needs the global enable
	a_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_ff.mctl[GLOBAL_EN_BIT] |-> !core_irq)
		else $error("core request without global enable");
	// peripheral flags alone need the peripheral enable
	a_periph_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!s_ff.mctl[PERIPH_EN_BIT] && s_ff.mctl[2:0] == 3'h0 |->
		!core_irq)
		else $error("peripheral request without peripheral enable");
	// an enabled pending flag raises the request
	a_req_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		core_irq == req_of(s_ff.mctl, s_ff.pen1, s_ff.pen2,
		fl.req1, fl.req2))
		else $error("core request does not match flags and enables");
	// flag is set one edge after its pulse, whatever the enables
	a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		adc_done_evt ##1 1'b1 |-> fl.req1[6] ##1 fl.req1[6] ||
		$past(fl.wr1))
		else $error("adc flag not set by its event");
	// serial flags ignore software writes
	a_serial_ro: assert property (@(posedge hclk) disable iff (!hresetn)
		fl.wr1 |=> fl.req1[SER_RX_BIT] == $past(serial_receive_lvl) &&
		fl.req1[SER_TX_BIT] == $past(serial_transmit_lvl))
		else $error("serial flag followed a software write");
	// second enable keeps only its three bits
	a_pen2_bits: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_ff.pen2 & ~REG2_MASK) == 8'h00)
		else $error("unimplemented enable bit set");
	// a write, two cycles with no write, then a read returns the data
	a_write_read: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_ok && hwrite && hit(haddr, OFS_PEN1) ##1
		(!(addr_ok && hwrite)) [*2] ##1
		addr_ok && !hwrite && hit(haddr, OFS_PEN1) |=>
		hrdata[7:0] == $past(hwdata[7:0], 3))
		else $error("read did not return written enable");
	// timer0 flag survives a clearing write in its event cycle
	a_t0_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		timer0_overflow_evt |=> s_ff.mctl[T0_PEND_BIT])
		else $error("timer0 flag lost its event");
endmodule
`default_nettype wire

// ==== verif/pif_src_model.sv ====
// partner model: peripheral event sources and held request levels
`timescale 1ns/10ps
`default_nettype none
module pif_src_model
(
	// clock
	input wire logic hclk,
	// set pulses laid out like the flag registers
	output logic [7:0] p1,
	output logic [7:0] p2,
	output logic [7:0] pm,
	// held levels: serial receive/transmit, pin change
	output logic [1:0] ser,
	output logic pchg
);
	// every source is quiet at time zero
	initial
	begin
		p1 = 8'h00;
		p2 = 8'h00;
		pm = 8'h00;
		ser = 2'h0;
		pchg = 1'b0;
	end
	// one-cycle pulse launched just after the d-th edge from now
	task automatic fire(input int d, input logic [7:0] a, b, c);
		repeat (d) @(posedge hclk);
		p1 <= a;
		p2 <= b;
		pm <= c;
		@(posedge hclk);
		p1 <= 8'h00;
		p2 <= 8'h00;
		pm <= 8'h00;
	endtask
	// levels change just after an edge and then hold
	task automatic level(input logic [1:0] s, input logic c);
		@(posedge hclk);
		ser <= s;
		pchg <= c;
	endtask
endmodule
`default_nettype wire

// ==== verif/pif_top_test.sv ====
// testbench: registers, flags and interrupt requests of the flag block
`timescale 1ns/10ps
`default_nettype none
module pif_top_test
	import pif_pkg::*;
;
	logic hclk; // bus clock
	logic hresetn; // active-low reset
	logic [7:0] haddr; // address phase
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata; // data phase
	logic hreadyout; // slave answer, fed back as hready
	logic [31:0] hrdata;
	logic hresp;
	logic core_irq; // request to the core
	logic evt_irq; // event summary request
	logic [7:0] p1, p2, pm; // source pulses
	logic [1:0] ser; // serial levels
	logic pchg; // pin change level
	logic [31:0] rd; // last read word
	logic [7:0] m; // one-hot source mask
	int miscompares;
	int n_tests;
	// far side
	pif_src_model u_src (.hclk(hclk), .p1(p1), .p2(p2), .pm(pm),
		.ser(ser), .pchg(pchg));
	// block under test; one slave, so hready is its own answer
	pif_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .timer1_gate_evt(p1[7]),
		.adc_done_evt(p1[6]), .sync_port_evt(p1[3]),
		.capcmp_one_evt(p1[2]), .timer2_match_evt(p1[1]),
		.timer1_overflow_evt(p1[0]), .serial_receive_lvl(ser[1]),
		.serial_transmit_lvl(ser[0]), .osc_fail_evt(p2[7]),
		.bus_collision_evt(p2[3]), .capcmp_two_evt(p2[0]),
		.timer0_overflow_evt(pm[2]), .ext_pin_evt(pm[1]),
		.pin_change_lvl(pchg), .core_irq(core_irq), .evt_irq(evt_irq));
	// 100 ns clock
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// compare a seen word with its expectation
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counts, verdict, stop
	task automatic end_of_test;
		$display("counts: %0d compares, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for hready high at a rising edge
	task automatic wait_ready;
		int i;
		i = 0;
		do
		begin
			@(posedge hclk);
			i++;
		end
		while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1)
		begin
			miscompares++;
			end_of_test;
		end
	endtask
	// single word transfer; read data taken at the data phase edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask
	// read one register and compare it
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// let requests settle, then compare both interrupt outputs
	task automatic irq_chk(input logic c, input logic e);
		repeat (3) @(posedge hclk);
		chk({30'h0, evt_irq, core_irq}, {30'h0, e, c});
	endtask
	// hold reset low for 16 cycles
	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	// main sequence
	initial
	begin
		hresetn = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		miscompares = 0;
		n_tests = 0;
		do_reset;
		for (int i = 0; i < 7; i++)
			rchk(8'(i * 4), 32'h0);
		$display("test 1 done: reset values");
		// all ones: only implemented writable bits stick
		bus(1'b1, OFS_PEN1, 32'hffff_ffff);
		rchk(OFS_PEN1, 32'h0000_00ff);
		bus(1'b1, OFS_PEN2, 32'hffff_ffff);
		rchk(OFS_PEN2, 32'h0000_0089);
		bus(1'b1, OFS_PREQ2, 32'hffff_ffff);
		rchk(OFS_PREQ2, 32'h0000_0089);
		bus(1'b1, OFS_PREQ1, 32'hffff_ffff);
		rchk(OFS_PREQ1, 32'h0000_00cf);
		bus(1'b1, OFS_MCTL, 32'hffff_ffff);
		rchk(OFS_MCTL, 32'h0000_00fe);
		bus(1'b1, 8'h20, 32'hffff_ffff);
		rchk(8'h20, 32'h0);
		// reset in mid-run clears everything again
		do_reset;
		for (int i = 0; i < 7; i++)
			rchk(8'(i * 4), 32'h0);
		irq_chk(1'b0, 1'b0);
		$display("test 2 done: access kinds");
		// each bit position, first and second register sources together, all enables off
		for (int b = 0; b < 8; b++)
		begin
			m = 8'h01 << b;
			bus(1'b1, OFS_PREQ1, 32'h0);
			bus(1'b1, OFS_PREQ2, 32'h0);
			u_src.fire(1, m, m, 8'h00);
			rchk(OFS_PREQ1, {24'h0, m & 8'hcf});
			rchk(OFS_PREQ2, {24'h0, m & 8'h89});
		end
		u_src.fire(1, 8'h00, 8'h00, 8'h06);
		repeat (5) @(posedge hclk);
		rchk(OFS_PREQ2, 32'h0000_0080);
		rchk(OFS_MCTL, 32'h0000_0006);
		irq_chk(1'b0, 1'b0);
		$display("test 3 done: flags set regardless of enables");
		// clear flags before enabling, then gate the request
		bus(1'b1, OFS_PREQ2, 32'h0);
		bus(1'b1, OFS_MCTL, 32'h0);
		bus(1'b1, OFS_PEN2, 32'h08);
		bus(1'b1, OFS_MCTL, 32'h80);
		u_src.fire(1, 8'h00, 8'h08, 8'h00);
		irq_chk(1'b0, 1'b0);
		bus(1'b1, OFS_MCTL, 32'hc0);
		irq_chk(1'b1, 1'b0);
		bus(1'b1, OFS_MCTL, 32'h40);
		irq_chk(1'b0, 1'b0);
		bus(1'b1, OFS_MCTL, 32'hc0);
		bus(1'b1, OFS_PEN2, 32'h00);
		irq_chk(1'b0, 1'b0);
		bus(1'b1, OFS_PEN2, 32'h08);
		irq_chk(1'b1, 1'b0);
		bus(1'b1, OFS_PREQ2, 32'h0);
		irq_chk(1'b0, 1'b0);
		$display("test 4 done: request gating");
		// set pulse in the very cycle that a zero is written
		fork
			bus(1'b1, OFS_PREQ2, 32'h0);
			u_src.fire(2, 8'h01, 8'h80, 8'h00);
		join
		rchk(OFS_PREQ2, 32'h0000_0080);
		$display("test 5 done: set against clear");
		// serial flags follow their levels and ignore writes
		u_src.level(2'h3, 1'b1);
		// gate flag from test 3 and overflow flag from test 5 still pend
		rchk(OFS_PREQ1, 32'h0000_00b1);
		bus(1'b1, OFS_PREQ1, 32'h0);
		rchk(OFS_PREQ1, 32'h0000_0030);
		rchk(OFS_MCTL, 32'h0000_00c1);
		u_src.level(2'h0, 1'b0);
		rchk(OFS_PREQ1, 32'h0);
		$display("test 6 done: serial levels");
		// event interrupt: clear, raise, mask
		bus(1'b1, OFS_EVT_CLR, 32'h3);
		rchk(OFS_EVT_STAT, 32'h0);
		bus(1'b1, OFS_EVT_EN, 32'h1);
		u_src.fire(1, 8'h04, 8'h00, 8'h00);
		irq_chk(1'b0, 1'b1);
		rchk(OFS_EVT_STAT, 32'h1);
		bus(1'b1, OFS_EVT_EN, 32'h0);
		irq_chk(1'b0, 1'b0);
		bus(1'b1, OFS_EVT_CLR, 32'h1);
		rchk(OFS_EVT_STAT, 32'h0);
		$display("test 7 done: event interrupt");
		end_of_test;
	end
endmodule
`default_nettype wire
